// ===== shared/branch_incr_pkg.sv
// Purpose: shared constants and carriers for the branch/increment executor
// Assumes: one oscillator period per clk edge
// Notes: opcode fields follow the instruction word layout
package branch_incr_pkg;

  // ----------------------------------------------------------------
  // opcode fields
  // ----------------------------------------------------------------
  localparam logic [7:0] BRANCH_OP1 = 8'hEF;
  localparam logic [3:0] BRANCH_OP2 = 4'hF;
  localparam logic [5:0] INCR_FILE_OP = 6'h0A;
  localparam int OP1_HI = 15;
  localparam int OP1_LO = 8;
  localparam int OP6_LO = 10;
  localparam int DEST_BIT = 9;
  localparam int ACC_BIT = 8;
  localparam logic [7:0] INDEXED_MAX = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;

  // ----------------------------------------------------------------
  // timing and reset values
  // ----------------------------------------------------------------
  localparam int QUARTERS = 4;
  localparam logic [1:0] Q_RESET = 2'h0;
  localparam logic [20:0] PC_RESET = 21'h00000;
  localparam logic [7:0] W_RESET = 8'h00;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [4:0] FLAGS_RESET = 5'h00;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic neg;
    logic ovf;
    logic zero;
    logic dcarry;
    logic carry;
  } flags_t;

  typedef struct packed {
    logic wr;
    logic [11:0] addr;
    logic [7:0] data;
  } file_req_t;

endpackage : branch_incr_pkg

// ===== verilog/file_ram.sv
// Purpose: small file register memory with registered read data
// Assumes: single clock, read address presented one edge ahead
// Notes: write and read may target the same word; read sees old data
`timescale 1ns/1ps
module file_ram #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  // clock
  input wire logic clk,
  // access
  input wire logic wr,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  initial begin
    if (AW < 1 || AW > 16) $error("file_ram: unsupported AW");
  end

  // zero start keeps increment results and flags defined from the first use
  logic [DW-1:0] mem [0:(1<<AW)-1] = '{default: '0};

  always_ff @(posedge clk) begin
    if (wr) mem[waddr] <= wdata;
    rdata <= mem[raddr];
  end
endmodule : file_ram

// ===== verilog/branch_increment_exec.sv
// Purpose: executes the absolute branch and file increment instructions
// Assumes: instr words arrive from the fetch stage with instr_valid
// Notes: one instruction cycle is four clk quarters; pll mode is outside
`timescale 1ns/1ps

// Overview of operation
// - branch is two words, opcodes EF and F
// - 20-bit literal loads pc bits 20:1
// - branch always takes two instruction cycles
// - q4 of first cycle writes pc
// - increment decoded from 001010, adds one
// - dest bit picks accumulator or file
// - access bit picks access or selected bank
// - extended set, low address uses indexed offset
// - instruction cycle lasts four oscillator periods
module branch_increment_exec #(
  parameter int AW = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // instruction stream
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  input wire logic ext_set_en,
  input wire logic [AW-1:0] index_base,
  input wire logic [3:0] bank_selector,
  // state out
  output logic [20:0] pc,
  output logic [7:0] wreg,
  output branch_incr_pkg::flags_t flags,
  output logic [1:0] quarter,
  output logic busy,
  output logic cycle_end
);
  initial begin
    if (AW != 12) $error("branch_increment_exec: AW must be 12");
  end

  // ----------------------------------------------------------------
  // quarter sequencer
  // ----------------------------------------------------------------
  typedef enum {IDLE, BR_FIRST, BR_NOP, INC_EXEC} state_t;
  state_t state_r, state_nxt;
  logic [1:0] q_r;
  logic [20:0] pc_r, pc_nxt;
  logic [7:0] w_r, w_nxt;
  branch_incr_pkg::flags_t flags_r, flags_nxt;
  logic [7:0] lit_lo_r;
  logic [11:0] faddr_r;
  logic dest_r;

  wire q4 = (q_r == 2'(branch_incr_pkg::QUARTERS - 1));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) q_r <= branch_incr_pkg::Q_RESET;
    else q_r <= q_r + 2'h1;
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // first branch word
  wire is_branch = (instr[branch_incr_pkg::OP1_HI:branch_incr_pkg::OP1_LO]
                    == branch_incr_pkg::BRANCH_OP1);
  wire is_second = (instr[15:12] == branch_incr_pkg::BRANCH_OP2);
  wire is_incr = (instr[15:branch_incr_pkg::OP6_LO] == branch_incr_pkg::INCR_FILE_OP);
  wire start = instr_valid && (q_r == branch_incr_pkg::Q_RESET) && (state_r == IDLE);

  // effective address: indexed offset in low access range, else access split or bank
  function automatic logic [11:0] eff_addr(input logic acc, input logic ext,
                                           input logic [7:0] f,
                                           input logic [11:0] base,
                                           input logic [3:0] bank);
    if (!acc && ext && f <= branch_incr_pkg::INDEXED_MAX)
      return base + {4'h0, f};
    else if (!acc)
      return (f < branch_incr_pkg::ACCESS_SPLIT) ? {4'h0, f} : {4'hF, f};
    else
      return {bank, f};
  endfunction : eff_addr

  wire [11:0] dec_addr = eff_addr(instr[branch_incr_pkg::ACC_BIT], ext_set_en,
                                  instr[7:0], index_base, bank_selector);

  // ----------------------------------------------------------------
  // file memory
  // ----------------------------------------------------------------
  logic [7:0] fdata;
  branch_incr_pkg::file_req_t wreq;
  wire [8:0] sum = {1'b0, fdata} + 9'h001;
  wire [4:0] nib = {1'b0, fdata[3:0]} + 5'h01;

  assign wreq.wr = (state_r == INC_EXEC) && q4 && dest_r;
  assign wreq.addr = faddr_r;
  assign wreq.data = sum[7:0];

  file_ram #(.AW(AW), .DW(8)) u_ram (
    .clk(clk),
    .wr(wreq.wr),
    .waddr(wreq.addr),
    .wdata(wreq.data),
    .raddr(start ? dec_addr : faddr_r),
    .rdata(fdata)
  );

  // ----------------------------------------------------------------
  // execute
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    w_nxt = w_r;
    flags_nxt = flags_r;
    case (state_r)
      IDLE: begin
        if (start && is_branch) state_nxt = BR_FIRST;
        else if (start && is_incr) state_nxt = INC_EXEC;
      end
      BR_FIRST: begin
        // high literal read and pc write in q4
        if (q4) begin
          if (instr_valid && is_second) pc_nxt = {instr[11:0], lit_lo_r, 1'b0};
          state_nxt = BR_NOP;
        end
      end
      BR_NOP: begin
        if (q4) state_nxt = IDLE;
      end
      INC_EXEC: begin
        if (q4) begin
          flags_nxt.carry = sum[8];
          flags_nxt.dcarry = nib[4];
          flags_nxt.zero = (sum[7:0] == 8'h00);
          flags_nxt.neg = sum[7];
          flags_nxt.ovf = (fdata == 8'h7F);
          if (!dest_r) w_nxt = sum[7:0];
          pc_nxt = pc_r + 21'h00002;
          state_nxt = IDLE;
        end
      end
      default: state_nxt = IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= IDLE;
      pc_r <= branch_incr_pkg::PC_RESET;
      w_r <= branch_incr_pkg::W_RESET;
      flags_r <= branch_incr_pkg::FLAGS_RESET;
    end else begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      w_r <= w_nxt;
      flags_r <= flags_nxt;
    end
  end

  // operand capture at the decode quarter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lit_lo_r <= 8'h00;
      faddr_r <= 12'h000;
      dest_r <= 1'b0;
    end else if (start) begin
      lit_lo_r <= instr[7:0];
      faddr_r <= dec_addr;
      dest_r <= instr[branch_incr_pkg::DEST_BIT];
    end
  end

  assign pc = pc_r;
  assign wreg = w_r;
  assign flags = flags_r;
  assign quarter = q_r;
  assign busy = (state_r != IDLE);
  assign cycle_end = q4;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence br_seq;
    (state_r == BR_FIRST) [*3] ##1 (state_r == BR_NOP) [*4];
  endsequence

  chk_branch_two_cycles:
    assert property (@(posedge clk) disable iff (!rstn)
      (start && is_branch) |=> br_seq ##1 (state_r == IDLE))
    else $error("branch did not take two cycles");

  chk_quarter_wrap:
    assert property (@(posedge clk) disable iff (!rstn)
      (q_r == 2'h0) |=> (q_r == 2'h1) ##3 (q_r == 2'h0))
    else $error("quarter count wrong");

  chk_pc_only_q4:
    assert property (@(posedge clk) disable iff (!rstn)
      (state_r == BR_FIRST && !q4) |=> $stable(pc_r))
    else $error("pc moved before q4");

  chk_pc_literal:
    assert property (@(posedge clk) disable iff (!rstn)
      (state_r == BR_FIRST && q4 && instr_valid && is_second)
      |=> pc_r == {$past(instr[11:0]), lit_lo_r, 1'b0})
    else $error("pc not loaded with literal");

  chk_branch_flags:
    assert property (@(posedge clk) disable iff (!rstn)
      (state_r == BR_FIRST || state_r == BR_NOP) |=> $stable(flags_r))
    else $error("branch changed flags");

  chk_incr_one_cycle:
    assert property (@(posedge clk) disable iff (!rstn)
      (start && is_incr) |=> (state_r == INC_EXEC) [*3] ##1 (state_r == IDLE))
    else $error("increment not one cycle");

  chk_w_dest:
    assert property (@(posedge clk) disable iff (!rstn)
      (state_r == INC_EXEC && q4 && !dest_r) |=> w_r == $past(sum[7:0]))
    else $error("accumulator not written");

  chk_w_hold:
    assert property (@(posedge clk) disable iff (!rstn)
      (state_r == INC_EXEC && dest_r) |=> $stable(w_r))
    else $error("accumulator changed with file dest");

  chk_zero_flag:
    assert property (@(posedge clk) disable iff (!rstn)
      (state_r == INC_EXEC && q4) |=> flags_r.zero == ($past(fdata) == 8'hFF))
    else $error("zero flag wrong");

  chk_bank_addr:
    assert property (@(posedge clk) disable iff (!rstn)
      (start && is_incr && instr[8]) |=> faddr_r[11:8] == $past(bank_selector))
    else $error("bank not used");

  chk_indexed_addr:
    assert property (@(posedge clk) disable iff (!rstn)
      (start && is_incr && !instr[8] && ext_set_en && instr[7:0] <= 8'h5F)
      |=> faddr_r == $past(index_base) + {4'h0, $past(instr[7:0])})
    else $error("indexed address wrong");
endmodule : branch_increment_exec

// ===== test/branch_increment_exec_test.sv
// Purpose: self-checking bench for the branch/increment executor
// Assumes: file memory starts at zero, mirrored by a bench copy
// Notes: driver queues notes; monitor compares when busy falls
`timescale 1ns/1ps
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin num_errors++; \
  $display("MISMATCH t=%0t %s", $time, m); end end
module branch_increment_exec_test;
  typedef struct {
    logic [20:0] pc;
    logic [7:0] w;
    branch_incr_pkg::flags_t f;
    int len;
  } note_t;
  logic clk, rstn, instr_valid, ext_set_en, busy, cycle_end;
  logic [15:0] instr;
  logic [11:0] index_base;
  logic [3:0] bank_selector;
  logic [20:0] pc, exp_pc;
  logic [7:0] wreg;
  logic [1:0] quarter, q_prev;
  branch_incr_pkg::flags_t flags;
  int num_errors, check_count, busy_len, since_rst;
  logic busy_q;
  note_t notes[$];
  logic [19:0] ktab[7];
  logic [7:0] ftab[5];
  logic [7:0] exp_w;
  branch_incr_pkg::flags_t exp_f;
  logic [7:0] fmem[4096];

  branch_increment_exec #(.AW(12)) branch_increment_exec_inst (.clk(clk), .rstn(rstn),
    .instr(instr), .instr_valid(instr_valid), .ext_set_en(ext_set_en),
    .index_base(index_base), .bank_selector(bank_selector), .pc(pc), .wreg(wreg),
    .flags(flags), .quarter(quarter), .busy(busy), .cycle_end(cycle_end));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task results;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // bounded wait for a free quarter 0
  task wait_idle;
    int i;
    for (i = 0; i < 40 && !(quarter === 2'h0 && busy === 1'b0); i++) @(negedge clk);
    if (i == 40) begin num_errors++; $display("MISMATCH t=%0t timeout", $time); results(); end
  endtask : wait_idle

  task issue(input logic [15:0] w1, input logic [15:0] w2, input note_t n);
    int i;
    wait_idle();
    notes.push_back(n);
    instr = w1;
    instr_valid = 1'b1;
    @(negedge clk);
    instr = w2;
    for (i = 0; i < 20 && busy !== 1'b0; i++) @(negedge clk);
    // valid stays up so the next word can start at the very next free quarter 0
    if (i == 20) begin
      num_errors++;
      $display("MISMATCH t=%0t busy stuck", $time);
      results();
    end
  endtask : issue

  task branch(input logic [19:0] k, input logic good);
    note_t n;
    if (good) exp_pc = {k, 1'b0};
    n = '{exp_pc, exp_w, exp_f, 2 * branch_incr_pkg::QUARTERS - 1};
    issue({8'hEF, k[7:0]}, {good ? 4'hF : 4'hE, k[19:8]}, n);
  endtask : branch

  // predicts one increment from the addressing and flag rules
  task incr(input logic d, input logic a, input logic [7:0] f);
    note_t n;
    logic [11:0] ea;
    logic [7:0] v;
    if (a) ea = {bank_selector, f};
    else if (ext_set_en && f < 8'h60) ea = index_base + {4'h0, f};
    else if (f < 8'h60) ea = {4'h0, f};
    else ea = {4'hF, f};
    v = fmem[ea];
    exp_f.carry = (v == 8'hFF);
    exp_f.dcarry = (v[3:0] == 4'hF);
    exp_f.neg = (v >= 8'h7F && v != 8'hFF);
    exp_f.ovf = (v == 8'h7F);
    exp_f.zero = (v == 8'hFF);
    if (d) fmem[ea] = v + 8'h01;
    else exp_w = v + 8'h01;
    exp_pc = exp_pc + 21'h2;
    n = '{exp_pc, exp_w, exp_f, branch_incr_pkg::QUARTERS - 1};
    issue({branch_incr_pkg::INCR_FILE_OP, d, a, f}, 16'h0000, n);
  endtask : incr

  // ----------------------------------------------------------------
  // monitor
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    if (!rstn) begin busy_q = 1'b0; busy_len = 0; since_rst = 0; end
    else begin
      since_rst++;
      if (since_rst > 2) `CHK(quarter, q_prev + 2'h1, "quarter step")
      if (since_rst > 2) `CHK(cycle_end, quarter == 2'h3, "cycle end")
      if (busy === 1'b1) busy_len++;
      else if (busy_q) begin
        if (notes.size() == 0) `CHK(1'b0, 1'b1, "unexpected completion")
        else begin
          note_t n;
          n = notes.pop_front();
          `CHK(pc, n.pc, "pc")
          `CHK(wreg, n.w, "wreg")
          `CHK(flags, n.f, "flags")
          `CHK(busy_len, n.len, "cycle count")
        end
        busy_len = 0;
      end
      busy_q = (busy === 1'b1);
    end
    q_prev = quarter;
  end

  initial begin
    rstn = 1'b0;
    instr = 16'h0000;
    instr_valid = 1'b0;
    ext_set_en = 1'b0;
    index_base = 12'h000;
    bank_selector = 4'h0;
    exp_pc = 21'h00000;
    exp_w = branch_incr_pkg::W_RESET;
    exp_f = branch_incr_pkg::FLAGS_RESET;
    fmem = '{default: 8'h00};
    void'($urandom(32'hA154E57A));
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    `CHK(pc, branch_incr_pkg::PC_RESET, "reset pc")
    `CHK(flags, branch_incr_pkg::FLAGS_RESET, "reset flags")
    `CHK(wreg, branch_incr_pkg::W_RESET, "reset wreg")
    ktab = '{20'h00000, 20'hFFFFF, 20'h80001, 20'h0, 20'h0, 20'h0, 20'h0};
    for (int i = 3; i < 7; i++) ktab[i] = 20'($urandom());
    for (int i = 0; i < 7; i++) branch(ktab[i], 1'b1);
    branch(20'h12345, 1'b0);
    $display("test branch done");
    wait_idle();
    instr = 16'hFFFF;
    instr_valid = 1'b1;
    repeat (4) begin @(negedge clk); `CHK(busy, 1'b0, "unknown opcode") end
    // valid stays up; the next issued word replaces this one
    `CHK(pc, exp_pc, "unknown opcode pc")
    $display("test refuse done");
    ftab = '{8'h00, 8'h5F, 8'h60, 8'hFF, 8'($urandom())};
    for (int m = 0; m < 4; m++) begin
      for (int j = 0; j < 5; j++) begin
        ext_set_en = m[1];
        index_base = 12'($urandom());
        bank_selector = 4'($urandom());
        incr(m[0] ^ j[0], m[0], ftab[j]);
      end
    end
    // one word walked through a full wrap reaches every flag edge
    ext_set_en = 1'b0;
    repeat (256) incr(1'b1, 1'b0, 8'h05);
    incr(1'b0, 1'b0, 8'h05);
    $display("test increment done");
    branch(20'hABCDE, 1'b1);
    branch(20'h00001, 1'b1);
    $display("test back to back done");
    repeat (10) @(negedge clk);
    `CHK(notes.size(), 0, "pending notes")
    results();
  end
endmodule : branch_increment_exec_test
